/* File: spirq_pkg.sv */
// constants and helpers for the socket power and card irq control bank
// assumes byte-wide register access, one copy of the bank per socket
package spirq_pkg;

  // ==========================================
  // address decode
  localparam logic [3:0] WIN_PAGE = 4'h8;
  localparam logic [3:0] PORT_PAGE = 4'h0;
  localparam int SOCK_BIT = 6;
  localparam int HOLE_BIT = 7;
  localparam logic [5:0] IDX_ID = 6'h00;
  localparam logic [5:0] IDX_STAT = 6'h01;
  localparam logic [5:0] IDX_PWR = 6'h02;
  localparam logic [5:0] IDX_IGC = 6'h03;

  // ==========================================
  // reset values and fixed fields
  localparam logic [7:0] PWR_RESET = 8'h00;
  localparam logic [7:0] IGC_RESET = 8'h00;
  localparam logic [5:0] IDRW_RESET = 6'h04;
  localparam logic [1:0] ID_IFTYPE = 2'h2;
  localparam logic [3:0] REV_STD = 4'h2;

  // ==========================================
  // field positions
  localparam int PWR_OE = 7;
  localparam int PWR_AUTO = 5;
  localparam int PWR_VCCEN = 4;
  localparam int PWR_VCC_LO = 3;
  localparam int IGC_RING = 6 + 1;
  localparam int IGC_RST = 6;
  localparam int IGC_IO = 5;
  localparam int IGC_CSC = 4;
  localparam int STAT_PWR = 6;

  // writable bits of the power register per layout
  localparam logic [7:0] PWR_MASK_STD = 8'hB3;
  localparam logic [7:0] PWR_MASK_EXT = 8'h9B;

  // ==========================================
  // encodings
  localparam logic [1:0] VCC_5V = 2'h2;
  localparam logic [1:0] VCC_3V = 2'h3;
  localparam logic [1:0] VPP_VCC = 2'h1;
  localparam logic [1:0] VPP_12V = 2'h2;
  localparam logic [3:0] IRQ_NONE = 4'h0;
  localparam logic [3:0] IRQ_SMI = 4'h2;
  localparam int IRQ_LINES = 16;

  function automatic logic [7:0] pwr_mask(input logic std);
    return std ? PWR_MASK_STD : PWR_MASK_EXT;
  endfunction

endpackage

/* File: spirq_sock_if.sv */
// bundle between the register bank and one socket's decoder
// assumes the bank drives the raw fields and the decoder the results
`timescale 1ns/1ns
`default_nettype none
interface spirq_sock_if;
  logic [7:0] power;
  logic [7:0] igc;
  logic std_mode;
  logic sys_3v;
  logic is_32bit;
  logic oe;
  logic auto_sw;
  logic vcc_on;
  logic vcc_3v;
  logic vpp_vcc;
  logic vpp_12v;
  logic ring;
  logic rst;
  logic io;
  logic csc_pci;
  logic smi;
  logic [spirq_pkg::IRQ_LINES-1:0] irq;
  modport bank (output power, igc, std_mode, sys_3v, is_32bit,
    input oe, auto_sw, vcc_on, vcc_3v, vpp_vcc, vpp_12v, ring, rst, io, csc_pci, smi, irq);
  modport dec (input power, igc, std_mode, sys_3v, is_32bit,
    output oe, auto_sw, vcc_on, vcc_3v, vpp_vcc, vpp_12v, ring, rst, io, csc_pci, smi, irq);
endinterface
`default_nettype wire

/* File: spirq_dec.sv */
// combinational decode of one socket's control fields
// assumes the bank registers every result before it leaves the block
`timescale 1ns/1ns
`default_nettype none
module spirq_dec (
  spirq_sock_if.dec s
);

  logic [1:0] vcc_code;
  logic [1:0] vpp_code;
  logic [3:0] route;

  assign vcc_code = s.power[spirq_pkg::PWR_VCCEN:spirq_pkg::PWR_VCC_LO];
  assign vpp_code = s.power[1:0];
  assign route = s.igc[3:0];

  // ==========================================
  // power
  assign s.oe = s.power[spirq_pkg::PWR_OE]; // RQ1
  assign s.auto_sw = s.std_mode & s.power[spirq_pkg::PWR_AUTO]; // RQ3

  always_comb begin
    if (s.std_mode) begin
      s.vcc_on = s.power[spirq_pkg::PWR_VCCEN]; // RQ4
      s.vcc_3v = s.power[spirq_pkg::PWR_VCCEN] & s.sys_3v; // RQ4
    end else begin
      s.vcc_on = (vcc_code == spirq_pkg::VCC_5V) || (vcc_code == spirq_pkg::VCC_3V); // RQ7
      s.vcc_3v = (vcc_code == spirq_pkg::VCC_3V); // RQ7
    end
  end

  // vpp only acts while vcc is on; reserved code connects nothing
  assign s.vpp_vcc = s.vcc_on & (vpp_code == spirq_pkg::VPP_VCC); // RQ5 RQ6
  assign s.vpp_12v = s.vcc_on & (vpp_code == spirq_pkg::VPP_12V); // RQ5 RQ6

  // ==========================================
  // card control and irq routing
  assign s.ring = s.igc[spirq_pkg::IGC_RING]; // RQ11
  assign s.rst = ~s.igc[spirq_pkg::IGC_RST] & ~s.is_32bit; // RQ12
  assign s.io = s.igc[spirq_pkg::IGC_IO]; // RQ13
  assign s.csc_pci = s.igc[spirq_pkg::IGC_CSC] | (route == spirq_pkg::IRQ_NONE); // RQ14 RQ15
  assign s.smi = (route == spirq_pkg::IRQ_SMI); // RQ16

  always_comb begin
    for (int i = 0; i < spirq_pkg::IRQ_LINES; i++) begin
      s.irq[i] = (route == 4'(i)) && (route != spirq_pkg::IRQ_NONE) && (route != spirq_pkg::IRQ_SMI); // RQ16
    end
  end

endmodule
`default_nettype wire

/* File: spirq_regs.sv */
// socket power control and card irq/general control register bank
// assumes byte accesses on a 12-bit offset inside the socket space:
// page 0x8 (memory window) and page 0x0 (index port) reach the same bank
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RQ1 - output gate bit seven enables socket outputs
// RQ2 - standard layout: bits 6,3,2 read zero
// RQ3 - standard layout: bit five enables auto switching
// RQ4 - standard bit four enables vcc, system level
// RQ5 - vpp code: none, vcc, 12 V, reserved
// RQ6 - vpp ignored unless socket vcc is on
// RQ7 - extended layout: bits 4-3 select vcc level
// RQ8 - extended layout: bits 6,5,2 read zero
// RQ9 - revision 0010b selects the standard layout
// RQ10 - status bit six shows socket power on
// RQ11 - irq register bit seven enables ring indicate
// RQ12 - bit six zero holds 16-bit card reset
// RQ13 - bit five selects io card type
// RQ14 - bit four sends status change to pci
// RQ15 - route zero: no func irq, csc to pci
// RQ16 - route code selects smi or irq line
// RQ17 - per-socket copies, second socket 0x40 higher
// RQ18 - writes to reserved bits are discarded
module spirq_regs #(
  parameter int NS = 2
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [11:0] ADDR,
  input wire logic WR_STB,
  input wire logic RD_STB,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic RD_ACK,
  input wire logic SYS_VCC_3V,
  input wire logic [NS-1:0] CARD_32BIT,
  output logic [NS-1:0] CARD_OUT_EN,
  output logic [NS-1:0] AUTO_PWR_SW,
  output logic [NS-1:0] VCC_ON,
  output logic [NS-1:0] VCC_3V,
  output logic [NS-1:0] VPP_VCC,
  output logic [NS-1:0] VPP_12V,
  output logic [NS-1:0] RING_ON,
  output logic [NS-1:0] CARD_RESET,
  output logic [NS-1:0] IO_CARD,
  output logic [NS-1:0] CSC_TO_PCI,
  output logic [NS-1:0] FUNC_SMI,
  output logic [NS-1:0][spirq_pkg::IRQ_LINES-1:0] FUNC_IRQ
);

  // ==========================================
  // address decode
  logic addr_ok;
  logic sock;
  logic [5:0] idx;

  assign sock = ADDR[spirq_pkg::SOCK_BIT];
  assign idx = ADDR[5:0];
  // both pages map onto one bank; socket copies 0x40 apart
  assign addr_ok = ((ADDR[11:8] == spirq_pkg::WIN_PAGE) || (ADDR[11:8] == spirq_pkg::PORT_PAGE))
    && !ADDR[spirq_pkg::HOLE_BIT] && (int'(sock) < NS); // RQ17

  // ==========================================
  // per-socket registers
  logic [7:0] pwr_q [NS];
  logic [7:0] igc_q [NS];
  logic [5:0] idrw_q [NS];
  logic [NS-1:0] std_mode;

  spirq_sock_if sif [NS] ();

  for (genvar g = 0; g < NS; g++) begin : g_sock
    logic hit;
    assign hit = WR_STB && addr_ok && (int'(sock) == g); // RQ17
    assign std_mode[g] = (idrw_q[g][3:0] == spirq_pkg::REV_STD); // RQ9

    always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
        idrw_q[g] <= spirq_pkg::IDRW_RESET;
      end else if (hit && idx == spirq_pkg::IDX_ID) begin
        idrw_q[g] <= WDATA[5:0]; // RQ9
      end
    end

    // reserved positions of the layout in force at the write are never stored
    always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
        pwr_q[g] <= spirq_pkg::PWR_RESET;
      end else if (hit && idx == spirq_pkg::IDX_PWR) begin
        pwr_q[g] <= WDATA & spirq_pkg::pwr_mask(std_mode[g]); // RQ18 RQ2 RQ8
      end
    end

    always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
        igc_q[g] <= spirq_pkg::IGC_RESET;
      end else if (hit && idx == spirq_pkg::IDX_IGC) begin
        igc_q[g] <= WDATA;
      end
    end

    assign sif[g].power = pwr_q[g];
    assign sif[g].igc = igc_q[g];
    assign sif[g].std_mode = std_mode[g];
    assign sif[g].sys_3v = SYS_VCC_3V;
    assign sif[g].is_32bit = CARD_32BIT[g];

    spirq_dec u_dec (
      .s(sif[g])
    );

    // every socket output leaves from a flop
    always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
        CARD_OUT_EN[g] <= 1'b0;
        AUTO_PWR_SW[g] <= 1'b0;
        VCC_ON[g] <= 1'b0;
        VCC_3V[g] <= 1'b0;
        VPP_VCC[g] <= 1'b0;
        VPP_12V[g] <= 1'b0;
        RING_ON[g] <= 1'b0;
        CARD_RESET[g] <= 1'b0;
        IO_CARD[g] <= 1'b0;
        CSC_TO_PCI[g] <= 1'b0;
        FUNC_SMI[g] <= 1'b0;
        FUNC_IRQ[g] <= '0;
      end else begin
        CARD_OUT_EN[g] <= sif[g].oe; // RQ1
        AUTO_PWR_SW[g] <= sif[g].auto_sw; // RQ3
        VCC_ON[g] <= sif[g].vcc_on; // RQ4 RQ7
        VCC_3V[g] <= sif[g].vcc_3v;
        VPP_VCC[g] <= sif[g].vpp_vcc; // RQ6
        VPP_12V[g] <= sif[g].vpp_12v; // RQ6
        RING_ON[g] <= sif[g].ring; // RQ11
        CARD_RESET[g] <= sif[g].rst; // RQ12
        IO_CARD[g] <= sif[g].io; // RQ13
        CSC_TO_PCI[g] <= sif[g].csc_pci; // RQ14
        FUNC_SMI[g] <= sif[g].smi; // RQ16
        FUNC_IRQ[g] <= sif[g].irq; // RQ16
      end
    end
  end

  // ==========================================
  // read path
  logic [7:0] rd_d;
  logic [NS-1:0] pwr_stat;

  for (genvar g = 0; g < NS; g++) begin : g_stat
    assign pwr_stat[g] = sif[g].vcc_on;
  end

  always_comb begin
    rd_d = 8'h00;
    if (addr_ok) begin
      case (idx)
        spirq_pkg::IDX_ID: rd_d = {spirq_pkg::ID_IFTYPE, idrw_q[sock]};
        spirq_pkg::IDX_STAT: rd_d[spirq_pkg::STAT_PWR] = pwr_stat[sock]; // RQ10
        spirq_pkg::IDX_PWR: rd_d = pwr_q[sock] & spirq_pkg::pwr_mask(std_mode[sock]); // RQ2 RQ8
        spirq_pkg::IDX_IGC: rd_d = igc_q[sock];
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RDATA <= 8'h00;
      RD_ACK <= 1'b0;
    end else begin
      RD_ACK <= RD_STB;
      RDATA <= RD_STB ? rd_d : 8'h00;
    end
  end

  // ==========================================
  // assertions (socket 0 and cross-socket)
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  logic past_ok_q;
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      past_ok_q <= 1'b0;
    end else begin
      past_ok_q <= 1'b1;
    end
  end

  a_out_gate: assert property ( // RQ1
    past_ok_q |-> CARD_OUT_EN[0] == $past(pwr_q[0][spirq_pkg::PWR_OE]))
    else $error("output gate does not follow bit 7");

  // stale bits from the other layout may stay stored, so the read value is what must be clean
  a_std_rsvd: assert property ( // RQ2
    RD_STB && addr_ok && !sock && idx == spirq_pkg::IDX_PWR && std_mode[0]
      |=> (RDATA & ~spirq_pkg::PWR_MASK_STD) == 8'h00)
    else $error("standard reserved power bits read nonzero");

  a_auto_sw: assert property ( // RQ3
    past_ok_q |-> AUTO_PWR_SW[0] == ($past(std_mode[0]) && $past(pwr_q[0][spirq_pkg::PWR_AUTO])))
    else $error("auto switch output wrong");

  a_vcc_std: assert property ( // RQ4
    past_ok_q && $past(std_mode[0]) |->
      VCC_ON[0] == $past(pwr_q[0][spirq_pkg::PWR_VCCEN])
      && VCC_3V[0] == ($past(pwr_q[0][spirq_pkg::PWR_VCCEN]) && $past(SYS_VCC_3V)))
    else $error("standard vcc wrong");

  a_vpp_code: assert property ( // RQ5
    !(VPP_VCC[0] && VPP_12V[0]))
    else $error("two vpp levels at once");

  a_vpp_gate: assert property ( // RQ6
    (VPP_VCC[0] || VPP_12V[0]) |-> VCC_ON[0])
    else $error("vpp on without vcc");

  a_vcc_ext: assert property ( // RQ7
    past_ok_q && $past(!std_mode[0]) |->
      VCC_ON[0] == $past(pwr_q[0][spirq_pkg::PWR_VCCEN]))
    else $error("extended vcc wrong");

  a_ext_rsvd: assert property ( // RQ8
    RD_STB && addr_ok && !sock && idx == spirq_pkg::IDX_PWR && !std_mode[0]
      |=> (RDATA & ~spirq_pkg::PWR_MASK_EXT) == 8'h00)
    else $error("extended reserved bits read nonzero");

  a_mode_sel: assert property ( // RQ9
    WR_STB && addr_ok && !sock && idx == spirq_pkg::IDX_ID && WDATA[3:0] == spirq_pkg::REV_STD
      |=> std_mode[0])
    else $error("revision write did not select standard layout");

  a_pwr_stat: assert property ( // RQ10
    RD_STB && addr_ok && !sock && idx == spirq_pkg::IDX_STAT
      |=> RDATA[spirq_pkg::STAT_PWR] == $past(sif[0].vcc_on))
    else $error("power status bit wrong");

  a_ring_on: assert property ( // RQ11
    past_ok_q |-> RING_ON[0] == $past(igc_q[0][spirq_pkg::IGC_RING]))
    else $error("ring enable wrong");

  a_card_rst: assert property ( // RQ12
    past_ok_q |-> CARD_RESET[0] == ($past(!igc_q[0][spirq_pkg::IGC_RST]) && $past(!CARD_32BIT[0])))
    else $error("card reset wrong");

  a_io_type: assert property ( // RQ13
    past_ok_q |-> IO_CARD[0] == $past(igc_q[0][spirq_pkg::IGC_IO]))
    else $error("card type wrong");

  a_csc_route: assert property ( // RQ14
    past_ok_q && $past(igc_q[0][3:0]) != spirq_pkg::IRQ_NONE
      |-> CSC_TO_PCI[0] == $past(igc_q[0][spirq_pkg::IGC_CSC]))
    else $error("csc routing wrong");

  a_route_zero: assert property ( // RQ15
    past_ok_q && $past(igc_q[0][3:0]) == spirq_pkg::IRQ_NONE
      |-> CSC_TO_PCI[0] && FUNC_IRQ[0] == '0 && !FUNC_SMI[0])
    else $error("route zero wrong");

  a_smi_line: assert property ( // RQ16
    past_ok_q |-> FUNC_SMI[0] == ($past(igc_q[0][3:0]) == spirq_pkg::IRQ_SMI)
      && $countones(FUNC_IRQ[0]) <= 1)
    else $error("func irq route wrong");

  a_sock_sep: assert property ( // RQ17
    WR_STB && addr_ok && sock && idx == spirq_pkg::IDX_IGC |=> $stable(igc_q[0]))
    else $error("socket 1 write changed socket 0");

  a_rsvd_write: assert property ( // RQ18
    WR_STB && addr_ok && !sock && idx == spirq_pkg::IDX_PWR && std_mode[0]
      |=> (pwr_q[0] & ~spirq_pkg::PWR_MASK_STD) == 8'h00)
    else $error("reserved write stored");

  c_vcc_on: cover property (VCC_ON[0] && VPP_12V[0]);
  c_std_mode: cover property (std_mode[0] && AUTO_PWR_SW[0]);
  c_smi: cover property (FUNC_SMI[1]);
  c_rst_rel: cover property (!CARD_RESET[0] && IO_CARD[0]);

endmodule
`default_nettype wire

/* File: spirq_card_model.sv */
// socket-side model: card and power switch of each socket
// assumes it sees the bank's registered socket outputs
`timescale 1ns/1ns
`default_nettype none
module spirq_card_model #(
  parameter int NS = 2
) (
  input wire logic [NS-1:0] vcc_on,
  input wire logic [NS-1:0] card_reset,
  input wire logic [NS-1:0] kind_32,
  output logic [NS-1:0] is_32bit,
  output logic [NS-1:0] card_live
);
  // card kind is reported whether powered or not
  assign is_32bit = kind_32;
  // a 16-bit card runs only when powered and out of reset
  assign card_live = vcc_on & ~card_reset;
endmodule
`default_nettype wire

/* File: spirq_regs_tb_top.sv */
// self-checking bench for the socket power and card irq bank
// assumes two sockets and a one-cycle read answer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module spirq_regs_tb_top;
  typedef struct {logic [11:0] wa; logic [7:0] w; logic [11:0] ra; logic [7:0] r;} spirq_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [11:0] addr = 12'h000;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [7:0] wd = 8'h00;
  logic sys3 = 1'h0;
  logic [1:0] k32 = 2'h0;
  logic [1:0] is32, live, oe, aut, von, v3, vpv, vp12, ring, crst, io, csc, smi;
  logic [1:0][15:0] irq;
  logic [7:0] rdata;
  logic rack;
  logic on;
  logic [7:0] d;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int i;
  spirq_row_t rows [9] = '{
    '{12'h802, 8'hFF, 12'h802, 8'h9B},
    '{12'h842, 8'h6A, 12'h842, 8'h0A},
    '{12'h003, 8'hA5, 12'h803, 8'hA5},
    '{12'h843, 8'h5A, 12'h043, 8'h5A},
    '{12'h8C2, 8'hFF, 12'h8C2, 8'h00},
    '{12'h801, 8'hFF, 12'h801, 8'h40},
    '{12'h800, 8'h02, 12'h800, 8'h82},
    '{12'h802, 8'hFF, 12'h802, 8'hB3},
    '{12'h842, 8'hFF, 12'h842, 8'h9B}};

  spirq_regs #(.NS(2)) spirq_regs_i (.CORE_CLK(clk), .RESET(rst), .ADDR(addr), .WR_STB(wr),
    .RD_STB(rd), .WDATA(wd), .RDATA(rdata), .RD_ACK(rack), .SYS_VCC_3V(sys3), .CARD_32BIT(is32),
    .CARD_OUT_EN(oe), .AUTO_PWR_SW(aut), .VCC_ON(von), .VCC_3V(v3), .VPP_VCC(vpv), .VPP_12V(vp12),
    .RING_ON(ring), .CARD_RESET(crst), .IO_CARD(io), .CSC_TO_PCI(csc), .FUNC_SMI(smi), .FUNC_IRQ(irq));
  spirq_card_model #(.NS(2)) spirq_card_model_i (.vcc_on(von), .card_reset(crst), .kind_32(k32),
    .is_32bit(is32), .card_live(live));

  // ==========================================
  // clock, hang guard and bus tasks
  always #4 clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic wr8(input logic [11:0] ad, input logic [7:0] dt);
    @(negedge clk);
    addr = ad;
    wd = dt;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
  endtask

  task automatic rd8(input logic [11:0] ad, input logic [7:0] ex);
    @(negedge clk);
    addr = ad;
    rd = 1'h1;
    @(negedge clk);
    rd = 1'h0;
    `CHK(rack, 1'h1)
    `CHK(rdata, ex)
  endtask

  task automatic done(input string n);
    $display("test %s done, mismatches so far %0d", n, error_cnt);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    @(negedge clk);
    `CHK(oe, 2'h0)
    `CHK(crst, 2'h3)
    `CHK(csc, 2'h3)
    rd8(12'h802, 8'h00);
    rd8(12'h803, 8'h00);
    rd8(12'h800, 8'h84);
    done("reset");
    for (i = 0; i < 9; i++) begin
      wr8(rows[i].wa, rows[i].w);
      rd8(rows[i].ra, rows[i].r);
    end
    done("table");
    for (i = 0; i < 8; i++) begin
      sys3 = i[2];
      wr8(12'h802, {1'h1, 1'h0, i[1], i[0], 4'h2});
      @(negedge clk);
      `CHK(oe[0], 1'h1)
      `CHK(aut[0], i[1])
      `CHK(von[0], i[0])
      `CHK(v3[0], i[0] & i[2])
      `CHK(vp12[0], i[0])
    end
    done("standard");
    wr8(12'h800, 8'h04);
    rd8(12'h802, 8'h92);
    for (i = 0; i < 16; i++) begin
      d = {i[0], 2'h0, i[3:2], 1'h0, i[1:0]};
      on = i[3];
      wr8(12'h842, d);
      @(negedge clk);
      `CHK(oe[1], i[0])
      `CHK(aut[1], 1'h0)
      `CHK(von[1], on)
      `CHK(v3[1], i[3] & i[2])
      `CHK(vpv[1], on & (i[1:0] == 1))
      `CHK(vp12[1], on & (i[1:0] == 2))
      rd8(12'h841, {1'h0, on, 6'h00});
    end
    done("extended");
    for (i = 0; i < 16; i++) begin
      d = {i[0], i[1], i[2], i[3], i[3:0]};
      wr8(12'h843, d);
      @(negedge clk);
      `CHK(ring[1], d[7])
      `CHK(crst[1], ~d[6])
      `CHK(io[1], d[5])
      `CHK(csc[1], d[4] | (i == 0))
      `CHK(smi[1], (i == 2))
      `CHK(irq[1], (i == 0 || i == 2) ? 16'h0000 : 16'h0001 << i)
      `CHK(irq[0], 16'h0020)
    end
    k32 = 2'h2;
    wr8(12'h843, 8'h00);
    @(negedge clk);
    `CHK(crst, 2'h1)
    `CHK(live, 2'h2)
    done("routing");
    rst = 1'h1;
    @(negedge clk);
    `CHK(oe, 2'h0)
    rst = 1'h0;
    @(negedge clk);
    @(negedge clk);
    `CHK(csc, 2'h3)
    rd8(12'h800, 8'h84);
    rd8(12'h842, 8'h00);
    done("second reset");
    print_verdict();
  end
endmodule
`default_nettype wire
